// *** ssp_regs.vh ***
// register offsets, field positions, reset values, sizes and limits for the serial port
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SSP_OFS_CTRL0      4'h0
`define SSP_OFS_CTRL1      4'h1
`define SSP_OFS_DATA       4'h2
`define SSP_OFS_STATUS     4'h3
`define SSP_OFS_PRESCALE   4'h4
`define SSP_OFS_DMACTL     4'h5

// ----------------------------------------------------------------------------
// control zero fields: [3:0] size-1, [5:4] format, [6] polarity, [7] phase, [15:8] rate
// ----------------------------------------------------------------------------
`define SSP_C0_DSS_LSB     0
`define SSP_C0_FRF_LSB     4
`define SSP_C0_SPO_BIT     6
`define SSP_C0_SPH_BIT     7
`define SSP_C0_SCR_LSB     8
`define SSP_FMT_SPI        2'h0
`define SSP_FMT_SYNC       2'h1
`define SSP_FMT_SPI2       2'h2

// ----------------------------------------------------------------------------
// control one fields: [0] loopback, [1] enable, [2] slave mode
// ----------------------------------------------------------------------------
`define SSP_C1_LBM_BIT     0
`define SSP_C1_EN_BIT      1
`define SSP_C1_MS_BIT      2

// ----------------------------------------------------------------------------
// status fields: tx empty, tx not full, rx not empty, rx full, busy
// ----------------------------------------------------------------------------
`define SSP_ST_TFE_BIT     0
`define SSP_ST_TNF_BIT     1
`define SSP_ST_RNE_BIT     2
`define SSP_ST_RFF_BIT     3
`define SSP_ST_BSY_BIT     4

// ----------------------------------------------------------------------------
// dma control fields
// ----------------------------------------------------------------------------
`define SSP_DMA_RX_BIT     0
`define SSP_DMA_TX_BIT     1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SSP_RST_CTRL0      16'h0007
`define SSP_RST_CTRL1      16'h0000
`define SSP_RST_PRESCALE   8'h02
`define SSP_RST_DMACTL     2'h0

// ----------------------------------------------------------------------------
// sizes and limits
// ----------------------------------------------------------------------------
`define SSP_WORD_W         16
`define SSP_FIFO_DEPTH     8
`define SSP_MIN_BITS       4
`define SSP_CPS_MIN        8'h02

`endif

// *** ssp_fifo.v ***
// synchronous word fifo used for the transmit and receive paths of the serial port
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,      // system clock
    input  wire             rstn,     // async reset, active low
    input  wire             wr_en,    // push one word
    input  wire [WIDTH-1:0] wr_data,  // word to push
    input  wire             rd_en,    // pop one word
    output wire [WIDTH-1:0] rd_data,  // word at the head
    output wire             empty,    // no words held
    output wire             full      // depth words held
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wp_q;
    reg  [AW-1:0]    rp_q;
    reg  [AW:0]      cnt_q;
    wire             do_wr;
    wire             do_rd;

    assign do_wr   = wr_en && !full;
    assign do_rd   = rd_en && !empty;
    assign empty   = (cnt_q == {(AW+1){1'b0}});
    assign full    = (cnt_q == DEPTH[AW:0]);
    assign rd_data = mem[rp_q];

    // storage has no reset, it is only read where the count says valid
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wp_q] <= wr_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// *** ssp_top.v ***
// synchronous serial port: registers, bit clock divider, shifter and two fifos
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"

module ssp_top #(
    parameter DEPTH = `SSP_FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire        clk,          // system clock, 125 MHz
    input  wire        rstn,         // async reset, active low
    input  wire [3:0]  addr,         // register index
    input  wire [15:0] wdata,        // write data
    input  wire        wr,           // write strobe
    input  wire        rd,           // read strobe
    output reg  [15:0] rdata,        // read data, cycle after rd
    output reg         sclk_o,       // bit clock out (master)
    output reg         sclk_oe,      // bit clock drive enable
    input  wire        sclk_i,       // bit clock in (slave)
    output reg         fss_n_o,      // frame select out, active low
    output reg         fss_oe,       // frame select drive enable
    input  wire        fss_n_i,      // frame select in (slave)
    output reg         txd,          // serial data out
    output reg         txd_oe,       // serial data drive enable
    input  wire        rxd,          // serial data in
    output reg         dma_tx_req,   // tx fifo wants data
    output reg         dma_rx_req,   // rx fifo has data
    input  wire        dma_tx_wr,    // dma push into tx fifo
    input  wire [15:0] dma_tx_data,  // dma word for tx fifo
    input  wire        dma_rx_rd,    // dma pop from rx fifo
    output wire [15:0] dma_rx_data   // rx fifo head word for dma
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [15:0] ctrl0_q;
    reg  [15:0] ctrl1_q;
    reg  [7:0]  cps_q;
    reg  [1:0]  dmactl_q;

    wire [3:0]  dss     = ctrl0_q[`SSP_C0_DSS_LSB +: 4];
    wire [1:0]  frf     = ctrl0_q[`SSP_C0_FRF_LSB +: 2];
    wire        spo     = ctrl0_q[`SSP_C0_SPO_BIT];
    wire        sph     = ctrl0_q[`SSP_C0_SPH_BIT];
    wire [7:0]  serial_clock_rate_field     = ctrl0_q[`SSP_C0_SCR_LSB +: 8];
    wire        en      = ctrl1_q[`SSP_C1_EN_BIT];
    wire        slave   = ctrl1_q[`SSP_C1_MS_BIT];
    wire        lbm     = ctrl1_q[`SSP_C1_LBM_BIT];
    // words shorter than four bits are raised to four
    wire [3:0]  nbits_m1 = (dss < 4'h3) ? 4'h3 : dss;
    // sync format idles the clock low, spi formats follow polarity
    wire        idle_lvl = (frf == `SSP_FMT_SYNC) ? 1'b0 : spo;

    // ------------------------------------------------------------------------
    // fifos
    // ------------------------------------------------------------------------
    wire        tx_empty, tx_full, rx_empty, rx_full;
    wire [15:0] tx_head, rx_head;
    wire        cpu_dwr = wr && (addr == `SSP_OFS_DATA);
    wire        cpu_drd = rd && (addr == `SSP_OFS_DATA);
    wire        dma_tw  = dma_tx_wr && dmactl_q[`SSP_DMA_TX_BIT];
    wire        dma_rr  = dma_rx_rd && dmactl_q[`SSP_DMA_RX_BIT];
    reg         tx_pop, rx_push;
    reg  [15:0] rx_word;

    ssp_fifo #(.WIDTH(`SSP_WORD_W), .DEPTH(DEPTH), .AW(AW)) u_txf (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (cpu_dwr || dma_tw),
        .wr_data (cpu_dwr ? wdata : dma_tx_data),
        .rd_en   (tx_pop),
        .rd_data (tx_head),
        .empty   (tx_empty),
        .full    (tx_full)
    );

    ssp_fifo #(.WIDTH(`SSP_WORD_W), .DEPTH(DEPTH), .AW(AW)) u_rxf (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (rx_push),
        .wr_data (rx_word),
        .rd_en   (cpu_drd || dma_rr),
        .rd_data (rx_head),
        .empty   (rx_empty),
        .full    (rx_full)
    );
    assign dma_rx_data = rx_head;

    // ------------------------------------------------------------------------
    // register write and read port
    // ------------------------------------------------------------------------
    reg busy_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl0_q  <= `SSP_RST_CTRL0;
            ctrl1_q  <= `SSP_RST_CTRL1;
            cps_q    <= `SSP_RST_PRESCALE;
            dmactl_q <= `SSP_RST_DMACTL;
            rdata    <= 16'h0000;
        end else begin
            if (wr) begin
                case (addr)
                    `SSP_OFS_CTRL0:    ctrl0_q  <= wdata;
                    `SSP_OFS_CTRL1:    ctrl1_q  <= {13'h0000, wdata[2:0]};
                    `SSP_OFS_PRESCALE: cps_q    <= {wdata[7:1], 1'b0};
                    `SSP_OFS_DMACTL:   dmactl_q <= wdata[1:0];
                    default:           ;
                endcase
            end
            rdata <= 16'h0000;
            if (rd) begin
                case (addr)
                    `SSP_OFS_CTRL0:    rdata <= ctrl0_q;
                    `SSP_OFS_CTRL1:    rdata <= ctrl1_q;
                    `SSP_OFS_DATA:     rdata <= rx_empty ? 16'h0000 : rx_head;
                    `SSP_OFS_STATUS:   rdata <= {11'h000, busy_q, rx_full, !rx_empty,
                                                 !tx_full, tx_empty};
                    `SSP_OFS_PRESCALE: rdata <= {8'h00, cps_q};
                    `SSP_OFS_DMACTL:   rdata <= {14'h0000, dmactl_q};
                    default:           rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // two-stage bit clock divider: one tick per half bit period
    // ------------------------------------------------------------------------
    // half period = cps/2 * (1+scr) system clocks, so full = cps*(1+scr)
    reg  [6:0] pre_q;
    reg  [7:0] rate_q;
    wire [6:0] pre_half = (cps_q < `SSP_CPS_MIN) ? 7'h01 : cps_q[7:1];
    wire       pre_tick = (pre_q == pre_half - 7'h01);
    wire       half_tick = pre_tick && (rate_q == serial_clock_rate_field);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q  <= 7'h00;
            rate_q <= 8'h00;
        end else if (!busy_q || slave) begin
            pre_q  <= 7'h00;
            rate_q <= 8'h00;
        end else if (pre_tick) begin
            pre_q  <= 7'h00;
            rate_q <= half_tick ? 8'h00 : rate_q + 8'h01;
        end else begin
            pre_q  <= pre_q + 7'h01;
        end
    end

    // ------------------------------------------------------------------------
    // slave side: sample external clock, frame select used unregistered (inputs are synchronous)
    // ------------------------------------------------------------------------
    reg  sclk_d1_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_i;
        end
    end
    // slave relies on the master clock being slow enough to see both edges
    wire s_rise = sclk_i && !sclk_d1_q;
    wire s_fall = !sclk_i && sclk_d1_q;

    // ------------------------------------------------------------------------
    // shifter: sample on leading edge (phase 0, or sync format) or trailing edge (phase 1 in spi formats)
    // ------------------------------------------------------------------------
    reg  [15:0] sh_q;
    reg  [3:0]  bit_q;
    reg         lead_q;   // next master edge is a leading edge
    wire        samp_ph1 = (frf == `SSP_FMT_SYNC) ? 1'b0 : sph;
    wire        m_lead   = !slave && half_tick && lead_q;
    wire        m_trail  = !slave && half_tick && !lead_q;
    wire        s_lead   = slave && !fss_n_i && (spo ? s_fall : s_rise);
    wire        s_trail  = slave && !fss_n_i && (spo ? s_rise : s_fall);
    wire        lead     = m_lead || s_lead;
    wire        trail    = m_trail || s_trail;
    wire        samp     = samp_ph1 ? trail : lead;
    wire        shift    = samp_ph1 ? lead : trail;
    wire        rx_bit   = lbm ? txd : rxd;
    wire        last     = (bit_q == nbits_m1);
    // five-bit count so a full 16-bit word keeps every bit
    wire [15:0] rx_mask  = ~(16'hFFFF << ({1'b0, nbits_m1} + 5'h01));
    wire        start    = en && !busy_q && !tx_empty && (!slave || !fss_n_i);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q     <= 1'b0;
            sh_q       <= 16'h0000;
            bit_q      <= 4'h0;
            lead_q     <= 1'b1;
            tx_pop     <= 1'b0;
            rx_push    <= 1'b0;
            rx_word    <= 16'h0000;
            sclk_o     <= 1'b0;
            sclk_oe    <= 1'b0;
            fss_n_o    <= 1'b1;
            fss_oe     <= 1'b0;
            txd        <= 1'b0;
            txd_oe     <= 1'b0;
            dma_tx_req <= 1'b0;
            dma_rx_req <= 1'b0;
        end else begin
            tx_pop     <= 1'b0;
            rx_push    <= 1'b0;
            sclk_oe    <= en && !slave;
            fss_oe     <= en && !slave;
            txd_oe     <= en && (!slave || !fss_n_i);
            dma_tx_req <= dmactl_q[`SSP_DMA_TX_BIT] && !tx_full;
            dma_rx_req <= dmactl_q[`SSP_DMA_RX_BIT] && !rx_empty;
            if (!busy_q) begin
                sclk_o  <= idle_lvl;
                fss_n_o <= 1'b1;
                lead_q  <= 1'b1;
                // frame select rises for a cycle between words so the far side sees each frame
                if (start && !tx_pop && fss_n_o) begin
                    busy_q <= 1'b1;
                    tx_pop <= 1'b1;
                    bit_q  <= 4'h0;
                    // left-justify so the top of the word leaves first
                    sh_q   <= tx_head << (4'hF - nbits_m1);
                    txd    <= tx_head[nbits_m1];
                    fss_n_o <= slave;
                end
            end else begin
                if (half_tick) begin
                    sclk_o <= ~sclk_o;
                    lead_q <= ~lead_q;
                end
                if (samp) begin
                    sh_q <= {sh_q[14:0], rx_bit};
                end
                // in either phase the top of the shifter holds the next bit to send here
                if (shift && !(trail && last)) begin
                    txd <= sh_q[15];
                end
                // bits are counted on the trailing edge in both phases
                if (trail && !last) begin
                    bit_q <= bit_q + 4'h1;
                end
                if (trail && last) begin
                    busy_q  <= 1'b0;
                    rx_push <= !rx_full;
                    rx_word <= (samp_ph1 ? {sh_q[14:0], rx_bit} : sh_q) & rx_mask;
                end
                if (!en || (slave && fss_n_i)) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** ssp_top_sva.sv ***
// assertion checker for the serial port top, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module ssp_top_sva (
    input wire logic        clk,        // system clock
    input wire logic        rstn,       // async reset, active low
    input wire logic [3:0]  addr,       // register index
    input wire logic [15:0] wdata,      // write data
    input wire logic        wr,         // write strobe
    input wire logic        rd,         // read strobe
    input wire logic [15:0] rdata,      // read data
    input wire logic        sclk_o,     // bit clock out
    input wire logic        sclk_oe,    // bit clock enable
    input wire logic        fss_n_o,    // frame select out
    input wire logic        fss_oe,     // frame select enable
    input wire logic        dma_tx_req, // tx dma request
    input wire logic        dma_rx_req  // rx dma request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // shadow of the configuration, tracked from the register bus
    // ------------------------------------------------------------------
    logic [15:0] c0_q, cnt_q;
    logic [7:0]  ps_q;
    logic [4:0]  ne_q;
    logic [2:0]  c1_q;
    logic [1:0]  dm_q, dm_p;
    logic        mst_p, sck_q, seen_q;
    wire  [7:0]  ps   = (ps_q < 8'h02) ? 8'h02 : ps_q;
    wire  [15:0] half = {9'h000, ps[7:1]} * ({8'h00, c0_q[15:8]} + 16'h0001);
    wire  [4:0]  bits = (c0_q[3:0] < 4'h3) ? 5'h04 : {1'b0, c0_q[3:0]} + 5'h01;
    wire         idl  = c0_q[6] & (c0_q[5:4] != 2'h1);
    wire         mst  = c1_q[1] & ~c1_q[2];
    wire         tgl  = sclk_o != sck_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c0_q <= 16'h0007;
            c1_q <= 3'h0;
            ps_q <= 8'h02;
            {dm_q, dm_p, mst_p, sck_q, seen_q} <= 7'h00;
            cnt_q <= 16'h0000;
            ne_q <= 5'h00;
        end else begin
            if (wr && addr == 4'h0) c0_q <= wdata;
            if (wr && addr == 4'h1) c1_q <= wdata[2:0];
            if (wr && addr == 4'h4) ps_q <= {wdata[7:1], 1'b0};
            if (wr && addr == 4'h5) dm_q <= wdata[1:0];
            dm_p <= dm_q;
            mst_p <= mst;
            sck_q <= sclk_o;
            cnt_q <= tgl ? 16'h0001 : cnt_q + 16'h0001;
            seen_q <= !fss_n_o && (seen_q || tgl);
            // only leading edges count, so frame length is format independent
            if (fss_n_o) ne_q <= 5'h00;
            else if (tgl && sclk_o != idl) ne_q <= ne_q + 5'h01;
        end
    end
    AST_IDLE_LEVEL: assert property (fss_n_o && $past(fss_n_o) && !$past(wr) |-> sclk_o == idl)
        else $error("bit clock away from idle level between frames");
    AST_HALF_PERIOD: assert property (tgl && seen_q && !fss_n_o |-> cnt_q == half)
        else $error("bit clock half period differs from divider setting");
    AST_FRAME_EDGES: assert property (fss_oe && $rose(fss_n_o) |-> ne_q == bits)
        else $error("frame carried wrong number of bit clocks");
    AST_DRIVE_ENABLE: assert property (mst == mst_p |-> sclk_oe == mst && fss_oe == mst)
        else $error("drive enables disagree with master setting");
    AST_READ_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data nonzero outside read answer cycle");
    AST_DMA_TX_GATE: assert property (dm_q[1] == dm_p[1] && !dm_q[1] |-> !dma_tx_req)
        else $error("tx dma request while tx dma disabled");
    AST_DMA_RX_GATE: assert property (dm_q[0] == dm_p[0] && !dm_q[0] |-> !dma_rx_req)
        else $error("rx dma request while rx dma disabled");
    AST_PRESCALE_EVEN: assert property (rd && addr == 4'h4 |=> rdata[0] == 1'b0)
        else $error("prescale divisor read back odd");
endmodule
bind ssp_top ssp_top_sva u_sva (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fss_n_o(fss_n_o),
    .fss_oe(fss_oe), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
`default_nettype wire

// *** ssp_peer.sv ***
// external serial slave peripheral, sampling on the rising edge, clock idle low or high
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    input  wire logic        clk,   // system clock, used to watch the link
    input  wire logic        rstn,  // async reset, active low
    input  wire logic        sclk,  // bit clock from the port
    input  wire logic        sel_n, // frame select, active low
    input  wire logic        mosi,  // data from the port
    input  wire logic [15:0] reply, // word sent back in the next frame
    output var  logic        miso,  // data to the port
    output var  logic [15:0] got,   // last word received, right aligned
    output var  logic [7:0]  n_frm  // frames completed
);
    logic [15:0] sh_q, tx_q;
    logic        sck_q, sel_q, rs_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {sh_q, tx_q, got, n_frm, miso, sck_q, rs_q} <= 59'h0;
            sel_q <= 1'b1;
        end else begin
            sck_q <= sclk;
            sel_q <= sel_n;
            // a falling edge before the first rising one leads the frame: keep the bit
            rs_q  <= !sel_n && (rs_q || (!sck_q && sclk));
            if (!sel_n && sel_q) begin
                miso <= reply[15];
                tx_q <= {reply[14:0], 1'b0};
                sh_q <= 16'h0000;
            end else if (!sel_n && rs_q && sck_q && !sclk) begin
                miso <= tx_q[15];
                tx_q <= {tx_q[14:0], 1'b0};
            end else if (sel_n) begin
                // released line: never let the old bit linger
                miso <= ~miso;
            end
            if (!sel_n && !sck_q && sclk) sh_q <= {sh_q[14:0], mosi};
            if (sel_n && !sel_q) begin
                got <= sh_q;
                n_frm <= n_frm + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** ssp_tb.sv ***
// self-checking bench for the serial port top
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
    logic        sck_i = 1'b0, fs_n = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, dma_tx_data = 16'h0000;
    logic [15:0] rdata, dma_rx_data, got;
    logic        sclk_o, fss_n_o, txd, rxd, dma_tx_req, dma_rx_req;
    logic [7:0]  n_frm, n_q = 8'h00;
    logic [15:0] gq[$];
    logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hF};
    logic [15:0] re [5] = '{`SSP_RST_CTRL0, `SSP_RST_CTRL1, 16'h0003, 16'h0002, 16'h0000};
    int          n_fail = 0, checks = 0, cyc = 0;
    always #4 clk = ~clk;
    ssp_top u_ssp_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sclk_o(sclk_o), .sclk_oe(), .sclk_i(sck_i), .fss_n_o(fss_n_o),
        .fss_oe(), .fss_n_i(fs_n), .txd(txd), .txd_oe(), .rxd(rxd), .dma_tx_req(dma_tx_req),
        .dma_rx_req(dma_rx_req), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
        .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data));
    ssp_peer u_ssp_peer (.clk(clk), .rstn(rstn), .sclk(sclk_o), .sel_n(fss_n_o), .mosi(txd),
        .reply(pat(n_frm)), .miso(rxd), .got(got), .n_frm(n_frm));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] pat(input logic [7:0] n);
        return {n, ~n} ^ 16'h5A3C;
    endfunction
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_idle;
        logic [15:0] s;
        for (int i = 0; i < 3000; i++) begin
            rreg(`SSP_OFS_STATUS, s);
            if (s[`SSP_ST_TFE_BIT] === 1'b1 && s[`SSP_ST_BSY_BIT] === 1'b0) return;
        end
        n_fail++;
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        n_q <= n_frm;
        if (n_frm != n_q) gq.push_back(got);
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] v, w, msk, seed;
        logic [7:0]  n0, serial_clock_rate_field, cps, c;
        logic [1:0]  fmt;
        logic [3:0]  dss;
        int          nb;
        seed = 16'h002F;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (ra[i]) begin
            rreg(ra[i], v);
            `CHK("reset value", re[i], v)
        end
        foreach (re[i]) begin
            wreg(`SSP_OFS_PRESCALE, {8'h00, re[i][7:0] ^ 8'h05} ^ 16'h00FA);
            rreg(`SSP_OFS_PRESCALE, v);
            `CHK("prescale", ({8'h00, re[i][7:0] ^ 8'h05} ^ 16'h00FA) & 16'h00FE, v)
        end
        wreg(`SSP_OFS_CTRL1, 16'h0002);
        // random words over every size code and all three formats
        for (int k = 0; k < 32; k++) begin
            seed = lfsr(seed);
            c = 8'(seed[1:0] % 3);
            cps = 8'h02 + 8'h02 * c;
            serial_clock_rate_field = 8'(seed[3:2] % 3) + 8'h02 - c;
            fmt = 2'(k % 3);
            dss = 4'(k % 16);
            nb = (dss < 3) ? 4 : dss + 1;
            msk = 16'hFFFF >> (16 - nb);
            w = lfsr(seed);
            wreg(`SSP_OFS_CTRL0, {serial_clock_rate_field, {2{seed[4]}}, fmt, dss});
            wreg(`SSP_OFS_PRESCALE, {8'h00, cps});
            n0 = n_frm;
            wreg(`SSP_OFS_DATA, w);
            wait_idle();
            rreg(`SSP_OFS_DATA, v);
            `CHK("frame count", n0 + 8'h01, n_frm)
            if (fmt != 2'h2) begin
                `CHK("tx word", w & msk, got & msk)
                `CHK("rx word", pat(n0) >> (16 - nb), v)
            end
        end
        // fill the transmit fifo with the shifter held off, then drain
        wreg(`SSP_OFS_CTRL1, 16'h0000);
        wreg(`SSP_OFS_CTRL0, 16'h010F);
        n0 = n_frm;
        for (int i = 0; i < 9; i++) begin
            rreg(`SSP_OFS_STATUS, v);
            `CHK("tx not full", i < 8, v[`SSP_ST_TNF_BIT])
            wreg(`SSP_OFS_DATA, ~pat(8'(i)));
        end
        gq.delete();
        wreg(`SSP_OFS_CTRL1, 16'h0002);
        wait_idle();
        rreg(`SSP_OFS_STATUS, v);
        `CHK("rx full", 1'b1, v[`SSP_ST_RFF_BIT])
        `CHK("frames", 8, gq.size())
        for (int i = 0; i < 9; i++) begin
            rreg(`SSP_OFS_DATA, v);
            `CHK("rx order", (i < 8) ? pat(n0 + 8'(i)) : 16'h0000, v)
            if (i < 8 && i < gq.size()) `CHK("tx order", ~pat(8'(i)), gq[i])
        end
        // dma path in both directions
        wreg(`SSP_OFS_DMACTL, 16'h0003);
        repeat (3) @(posedge clk);
        `CHK("tx dma req", 1'b1, dma_tx_req)
        dma_tx_wr <= 1'b1;
        dma_tx_data <= seed;
        n0 = n_frm;
        @(posedge clk);
        dma_tx_wr <= 1'b0;
        wait_idle();
        repeat (3) @(posedge clk);
        #1 `CHK("rx dma req", 1'b1, dma_rx_req)
        `CHK("dma rx word", pat(n0), dma_rx_data)
        `CHK("dma tx word", seed, got)
        @(posedge clk);
        dma_rx_rd <= 1'b1;
        @(posedge clk);
        dma_rx_rd <= 1'b0;
        wreg(`SSP_OFS_DMACTL, 16'h0000);
        repeat (3) @(posedge clk);
        #1 `CHK("dma off", 2'h0, {dma_tx_req, dma_rx_req})
        // slave with loopback, outside clock edges six system clocks apart
        wreg(`SSP_OFS_CTRL1, 16'h0007);
        wreg(`SSP_OFS_CTRL0, 16'h0007);
        wreg(`SSP_OFS_DATA, w);
        fs_n <= 1'b0;
        repeat (16) begin
            repeat (6) @(posedge clk);
            sck_i <= ~sck_i;
        end
        repeat (6) @(posedge clk);
        fs_n <= 1'b1;
        rreg(`SSP_OFS_DATA, v);
        `CHK("slave loopback", w & 16'h00FF, v)
        tally_and_finish();
    end
endmodule
`default_nettype wire
